//--- core/ucrx_pkg.sv
// shared constants and types of the serial receive block
package ucrx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [4:0] OFS_STATUS_A  = 5'h00;
  localparam logic [4:0] OFS_CONTROL_B = 5'h04;
  localparam logic [4:0] OFS_CONTROL_C = 5'h08;
  localparam logic [4:0] OFS_DATA      = 5'h0c;
  localparam logic [4:0] OFS_BAUD      = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int STA_RXC_BIT   = 7;
  localparam int STA_FE_BIT    = 4;
  localparam int STA_DOR_BIT   = 3;
  localparam int STA_PE_BIT    = 2;
  localparam int STA_DBL_BIT   = 1;
  localparam int CTB_RECEIVE_COMPLETE_IRQ_ENABLE_BIT = 7;
  localparam int CTB_RECEIVER_ENABLE_BIT  = 4;
  localparam int CTB_SIZE2_BIT = 2;
  localparam int CTB_RX9_BIT   = 1;
  localparam int CTB_TX9_BIT   = 0;
  localparam int CTC_PM_HI_BIT = 5;
  localparam int CTC_PM_LO_BIT = 4;
  localparam int CTC_STOP_BIT  = 3;
  localparam int CTC_SIZE1_BIT = 2;
  localparam int CTC_SIZE0_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  RST_CONTROL_B = 8'h00;
  localparam logic [7:0]  RST_CONTROL_C = 8'h06;
  localparam logic        RST_DBL       = 1'b0;
  localparam logic [11:0] RST_BAUD      = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // character and sampling figures
  localparam logic [2:0] SIZE_NINE         = 3'h7;
  localparam logic [3:0] LEN_NINE          = 4'h9;
  localparam logic [3:0] LEN_EIGHT         = 4'h8;
  localparam logic [3:0] LEN_BASE          = 4'h5;
  localparam logic [4:0] SAMPLES_NORMAL    = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE    = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;

  ////////////////////////////////////////////////////////////////////////////
  // buffer entry layout
  localparam int ENT_FE  = 9;
  localparam int ENT_DOR = 10;
  localparam int ENT_PE  = 11;
  localparam int ENT_W   = 12;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP   = 5'b10000
  } ucrx_state_t;

endpackage : ucrx_pkg

//--- core/ucrx_bit_sampler.sv
// per-bit sample counter with three-sample majority vote
`timescale 1ns/100ps
`default_nettype none
module ucrx_bit_sampler
  import ucrx_pkg::*;
(
  input  wire logic clk_i,       // system clock
  input  wire logic rst_i,       // synchronous reset, high
  input  wire logic tick_i,      // one sample period elapsed
  input  wire logic restart_i,   // this tick took sample 1 of a start bit
  input  wire logic double_i,    // eight samples per bit
  input  wire logic rx_i,        // receive line
  output logic      vote_valid_o, // last centre sample taken
  output logic      vote_o       // majority of the centre samples
);

  logic [4:0] cnt_ff;
  logic [1:0] smp_ff;

  wire [4:0] last_smp  = double_i ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
  wire [4:0] first_smp = double_i ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  wire       at_first  = (cnt_ff == first_smp);
  wire       at_mid    = (cnt_ff == 5'(first_smp + 5'h01));
  wire       at_last   = (cnt_ff == 5'(first_smp + 5'h02));
  wire [4:0] nxt_cnt   = (cnt_ff == last_smp) ? 5'h01 : 5'(cnt_ff + 5'h01);

  assign vote_valid_o = tick_i & at_last & ~restart_i;
  assign vote_o       = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & rx_i) | (smp_ff[1] & rx_i); // [R19] [R20]

  // cnt_ff names the sample that the next tick takes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 5'h01;
      smp_ff <= 2'h0;
    end
    else if (restart_i)
    begin
      cnt_ff <= 5'h02;
    end
    else if (tick_i)
    begin
      cnt_ff <= nxt_cnt;
      if (at_first)
        smp_ff[0] <= rx_i;
      if (at_mid)
        smp_ff[1] <= rx_i;
    end
  end

endmodule : ucrx_bit_sampler
`default_nettype wire

//--- core/ucrx_fifo.sv
// small flip-flop fifo holding received characters with their flags
`timescale 1ns/100ps
`default_nettype none
module ucrx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,   // system clock
  input  wire logic             rst_i,   // synchronous reset, high
  input  wire logic             flush_i, // discard all entries
  input  wire logic             push_i,  // write one entry
  input  wire logic [WIDTH-1:0] data_i,  // entry to write
  input  wire logic             pop_i,   // drop the oldest entry
  output logic      [WIDTH-1:0] data_o,  // oldest entry
  output logic                  full_o,  // no room
  output logic                  empty_o  // nothing unread
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ff;
  logic [PW-1:0]    rd_ff;
  logic [CW-1:0]    cnt_ff;

  wire do_push = push_i & ~full_o;
  wire do_pop  = pop_i & ~empty_o;
  wire [PW-1:0] nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : PW'(wr_ff + 1'b1);
  wire [PW-1:0] nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : PW'(rd_ff + 1'b1);

  assign data_o  = mem_ff[rd_ff];
  assign full_o  = (cnt_ff == CW'(DEPTH));
  assign empty_o = (cnt_ff == '0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || flush_i)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (do_push)
        wr_ff <= nxt_wr;
      if (do_pop)
        rd_ff <= nxt_rd;
      if (do_push && !do_pop)
        cnt_ff <= CW'(cnt_ff + 1'b1);
      else if (do_pop && !do_push)
        cnt_ff <= CW'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem_ff[wr_ff] <= data_i;
  end

endmodule : ucrx_fifo
`default_nettype wire

//--- core/ucrx_receiver.sv
// serial receiver with two-entry buffer, status flags and wishbone registers
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R1] nine-bit mode shows the oldest character's ninth bit in control register B
// [R2] software reads status and ninth bit before the data byte
// [R3] ninth bit and error flags are buffered with each character
// [R4] receive-complete reads one exactly while unread data is buffered
// [R5] clearing receiver enable flushes the buffer, receive-complete goes zero
// [R6] interrupt requested while enabled and flag set, gated by global enable
// [R7] handler must read data to clear the flag or interrupt repeats
// [R8] status writes never change the error flags
// [R9] software writes zero to the error flag positions
// [R10] error flags raise no interrupt
// [R11] frame error shows the first stop bit of the oldest character was zero
// [R12] overrun set when buffer full, shifter waiting and new start seen
// [R13] overrun cleared when a frame moves into the buffer
// [R14] parity error valid until read, zero when checking is off
// [R15] checking compares computed data parity with received parity bit
// [R16] disabling stops reception at once and frees the receive pin
// [R17] software empties the buffer by reading data until flag is zero
// [R18] sixteen samples per bit, eight in double speed
// [R19] start bit voted on centre samples, rejected if two are high
// [R20] each bit decided by majority of three centre samples
// [R21] only the first stop bit is used
// [R22] unused upper data bits read as zero
// [R23] lower parity mode bit zero means even, one means odd
module ucrx_receiver
  import ucrx_pkg::*;
(
  input  wire logic        clk_i,           // system clock, 20 MHz
  input  wire logic        rst_i,           // synchronous reset, high
  input  wire logic        wb_cyc_i,        // wishbone cycle
  input  wire logic        wb_stb_i,        // wishbone strobe
  input  wire logic        wb_we_i,         // wishbone write
  input  wire logic [4:0]  wb_adr_i,        // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,        // wishbone byte enables
  input  wire logic [31:0] wb_dat_i,        // wishbone write data
  output logic      [31:0] wb_dat_o,        // wishbone read data
  output logic             wb_ack_o,        // wishbone acknowledge
  input  wire logic        global_irq_en_i, // global interrupt enable
  input  wire logic        serial_receive_pin_i, // receive line
  output logic             rx_pin_override_o, // receiver owns the pin
  output logic             rx_irq_o         // receive-complete interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0]        control_b_ff;
  logic [7:0]        control_c_ff;
  logic              dbl_ff;
  logic [11:0]       baud_ff;
  logic              ack_ff;
  logic [31:0]       dat_ff;
  logic              irq_ff;
  logic              override_ff;
  logic [11:0]       pre_ff;
  logic              prev_rx_ff;
  ucrx_state_t       state_ff;
  logic [3:0]        bit_cnt_ff;
  logic [8:0]        shr_ff;
  logic              par_ff;
  logic              perr_ff;
  logic              pend_valid_ff;
  logic [ENT_W-1:0]  pend_ff;
  logic              dor_wait_ff;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire take    = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr_lo   = take & wb_we_i & wb_sel_i[0];
  wire wr_hi   = take & wb_we_i & wb_sel_i[1];
  wire hit_sta = (wb_adr_i == OFS_STATUS_A);
  wire hit_ctb = (wb_adr_i == OFS_CONTROL_B);
  wire hit_ctc = (wb_adr_i == OFS_CONTROL_C);
  wire hit_dat = (wb_adr_i == OFS_DATA);
  wire hit_bd  = (wb_adr_i == OFS_BAUD);
  // popping on the take cycle: the read word is latched in the same edge
  wire pop     = take & ~wb_we_i & hit_dat;                       // [R3]

  ////////////////////////////////////////////////////////////////////////////
  // configuration
  wire       receiver_enable      = control_b_ff[CTB_RECEIVER_ENABLE_BIT];
  wire       pm_hi     = control_c_ff[CTC_PM_HI_BIT];
  wire       pm_lo     = control_c_ff[CTC_PM_LO_BIT];
  wire [2:0] size_code = {control_b_ff[CTB_SIZE2_BIT], control_c_ff[CTC_SIZE1_BIT], control_c_ff[CTC_SIZE0_BIT]};
  // reserved size codes fall back to eight bits
  wire [3:0] char_len  = (size_code == SIZE_NINE) ? LEN_NINE :
                         size_code[2] ? LEN_EIGHT : 4'(LEN_BASE + {2'h0, size_code[1:0]});

  ////////////////////////////////////////////////////////////////////////////
  // buffer
  logic [ENT_W-1:0] head;
  logic             buf_full;
  logic             buf_empty;
  logic [ENT_W-1:0] push_data;

  wire receive_complete_flag = ~buf_empty;                                          // [R4]

  ////////////////////////////////////////////////////////////////////////////
  // sample clock and edge detection
  wire tick = receiver_enable & (pre_ff == 12'h000);                         // [R18]
  wire fall = tick & prev_rx_ff & ~serial_receive_pin_i;
  wire st_idle  = (state_ff == RX_IDLE);
  wire restart  = st_idle & fall;
  logic vote_valid;
  logic vote;

  ucrx_bit_sampler u_sampler (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (tick),
    .restart_i    (restart),
    .double_i     (dbl_ff),
    .rx_i         (serial_receive_pin_i),
    .vote_valid_o (vote_valid),
    .vote_o       (vote)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame assembly
  wire        stop_done  = (state_ff == RX_STOP) & vote_valid;    // [R21]
  wire [8:0]  aligned    = shr_ff >> (4'h9 - char_len);           // [R22]
  wire        fe_now     = ~vote;                                 // [R11] [R20]
  wire [ENT_W-1:0] new_ent = {perr_ff, 1'b0, fe_now, aligned};
  wire        push_pend  = pend_valid_ff & ~buf_full;
  wire        push_new   = stop_done & ~buf_full & ~pend_valid_ff;
  wire        load_pend  = stop_done & (buf_full | pend_valid_ff);
  wire        push       = push_pend | push_new;
  wire        overrun    = restart & pend_valid_ff & buf_full;    // [R12]
  wire        last_data  = (bit_cnt_ff == 4'(char_len - 4'h1));

  always_comb
  begin
    push_data          = push_pend ? pend_ff : new_ent;
    push_data[ENT_DOR] = dor_wait_ff;                             // [R3]
  end

  ucrx_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .flush_i (~receiver_enable),                                             // [R5]
    .push_i  (push),
    .data_i  (push_data),
    .pop_i   (pop),
    .data_o  (head),
    .full_o  (buf_full),
    .empty_o (buf_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  wire fe_rd  = receive_complete_flag & head[ENT_FE];                               // [R11]
  wire dor_rd = receive_complete_flag & head[ENT_DOR];
  wire pe_rd  = receive_complete_flag & head[ENT_PE] & pm_hi;                       // [R14]
  wire [7:0] sta_rd = {receive_complete_flag, 2'h0, fe_rd, dor_rd, pe_rd, dbl_ff, 1'b0};
  wire [7:0] ctb_rd = {control_b_ff[7:2], receive_complete_flag & head[8], control_b_ff[CTB_TX9_BIT]}; // [R1]
  wire [7:0] dat_rd = receive_complete_flag ? head[7:0] : 8'h00;
  wire [31:0] rd_word = hit_sta ? {24'h000000, sta_rd} :
                        hit_ctb ? {24'h000000, ctb_rd} :
                        hit_ctc ? {24'h000000, control_c_ff} :
                        hit_dat ? {24'h000000, dat_rd} :
                        hit_bd  ? {20'h00000, baud_ff} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // bus registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= take;
      if (take && !wb_we_i)
        dat_ff <= rd_word;
    end
  end

  // only the speed bit of the status register is writable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dbl_ff <= RST_DBL;
    else if (wr_lo && hit_sta)
      dbl_ff <= wb_dat_i[STA_DBL_BIT];                            // [R8]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      control_b_ff <= RST_CONTROL_B;
      control_c_ff <= RST_CONTROL_C;
    end
    else
    begin
      if (wr_lo && hit_ctb)
        control_b_ff <= wb_dat_i[7:0] & ~(8'h01 << CTB_RX9_BIT);
      if (wr_lo && hit_ctc)
        control_c_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      baud_ff <= RST_BAUD;
    else
    begin
      if (wr_lo && hit_bd)
        baud_ff[7:0] <= wb_dat_i[7:0];
      if (wr_hi && hit_bd)
        baud_ff[11:8] <= wb_dat_i[11:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // error flags take no part in the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_ff      <= 1'b0;
      override_ff <= 1'b0;
    end
    else
    begin
      irq_ff      <= control_b_ff[CTB_RECEIVE_COMPLETE_IRQ_ENABLE_BIT] & receive_complete_flag & global_irq_en_i; // [R6] [R10]
      override_ff <= receiver_enable;                                        // [R16]
    end
  end

  assign wb_ack_o          = ack_ff;
  assign wb_dat_o          = dat_ff;
  assign rx_irq_o          = irq_ff;
  assign rx_pin_override_o = override_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sample prescaler
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !receiver_enable)
    begin
      pre_ff     <= 12'h000;
      prev_rx_ff <= 1'b1;
    end
    else if (tick)
    begin
      pre_ff     <= baud_ff;
      prev_rx_ff <= serial_receive_pin_i;
    end
    else
      pre_ff <= 12'(pre_ff - 12'h001);
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame state machine; disable abandons the frame in the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !receiver_enable)
    begin
      state_ff   <= RX_IDLE;                                      // [R16]
      bit_cnt_ff <= 4'h0;
      shr_ff     <= 9'h000;
      par_ff     <= 1'b0;
      perr_ff    <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        RX_IDLE:
        begin
          if (restart)
            state_ff <= RX_START;
        end
        RX_START:
        begin
          if (vote_valid)
          begin
            state_ff   <= vote ? RX_IDLE : RX_DATA;               // [R19]
            bit_cnt_ff <= 4'h0;
            shr_ff     <= 9'h000;
            par_ff     <= 1'b0;
            perr_ff    <= 1'b0;
          end
        end
        RX_DATA:
        begin
          if (vote_valid)
          begin
            shr_ff     <= {vote, shr_ff[8:1]};                    // [R20]
            par_ff     <= par_ff ^ vote;
            bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
            if (last_data)
              state_ff <= pm_hi ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY:
        begin
          if (vote_valid)
          begin
            perr_ff  <= par_ff ^ vote ^ pm_lo;                    // [R15] [R23]
            state_ff <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (vote_valid)
            state_ff <= RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift-register holding stage and overrun
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !receiver_enable)
    begin
      pend_valid_ff <= 1'b0;
      pend_ff       <= '0;
      dor_wait_ff   <= 1'b0;
    end
    else
    begin
      if (load_pend)
      begin
        pend_valid_ff <= 1'b1;
        pend_ff       <= new_ent;
      end
      else if (push_pend || overrun)
        pend_valid_ff <= 1'b0;
      // set wins over clear; both cannot meet since overrun needs a full buffer
      if (overrun)
        dor_wait_ff <= 1'b1;                                      // [R12]
      else if (push)
        dor_wait_ff <= 1'b0;                                      // [R13]
    end
  end

endmodule : ucrx_receiver
`default_nettype wire

//--- dv/ucrx_receiver_sva.sv
// concurrent checks on the ports of the serial receive block
`timescale 1ns/100ps
`default_nettype none
module ucrx_receiver_sva
  import ucrx_pkg::*;
(
  input wire logic        clk_i,                // clock
  input wire logic        rst_i,                // reset
  input wire logic        wb_cyc_i,             // cycle
  input wire logic        wb_stb_i,             // strobe
  input wire logic        wb_we_i,              // write
  input wire logic [4:0]  wb_adr_i,             // address
  input wire logic [3:0]  wb_sel_i,             // lanes
  input wire logic [31:0] wb_dat_i,             // write data
  input wire logic [31:0] wb_dat_o,             // read data
  input wire logic        wb_ack_o,             // ack
  input wire logic        global_irq_en_i,      // global enable
  input wire logic        serial_receive_pin_i, // line
  input wire logic        rx_pin_override_o,    // pin owned
  input wire logic        rx_irq_o              // interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic ctlb = take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CONTROL_B;
  sequence s_read(logic [4:0] a);
    take && !wb_we_i && wb_adr_i == a;
  endsequence
  sequence s_rx_off;
    ctlb && !wb_dat_i[CTB_RECEIVER_ENABLE_BIT];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ack_follows: assert property (take |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_irq_gated: assert property (rx_irq_o |-> $past(global_irq_en_i))
    else $error("interrupt while globally disabled");
  a_irq_needs_flag: assert property (s_read(OFS_STATUS_A) ##1 !wb_dat_o[STA_RXC_BIT] |-> !rx_irq_o)
    else $error("interrupt without receive complete");
  a_flush_drops_irq: assert property (s_rx_off |-> ##[1:3] !rx_irq_o)
    else $error("interrupt survives disable");
  a_pin_released: assert property (s_rx_off |-> ##[1:2] !rx_pin_override_o)
    else $error("pin not released");
  a_pin_claimed: assert property (ctlb && wb_dat_i[CTB_RECEIVER_ENABLE_BIT] |-> ##[1:2] rx_pin_override_o)
    else $error("pin not claimed");
  a_upper_bits_zero: assert property (take && !wb_we_i && wb_adr_i != OFS_BAUD |=> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i > OFS_BAUD |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_spare: assert property (s_read(OFS_STATUS_A) |=> wb_dat_o[6:5] == 2'h0 && !wb_dat_o[0])
    else $error("status spare bits set");
  a_rdata_holds: assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without read");
endmodule : ucrx_receiver_sva
bind ucrx_receiver ucrx_receiver_sva i_ucrx_receiver_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .global_irq_en_i(global_irq_en_i), .serial_receive_pin_i(serial_receive_pin_i),
  .rx_pin_override_o(rx_pin_override_o), .rx_irq_o(rx_irq_o)
);
`default_nettype wire

//--- dv/ucrx_tx_model.sv
// behavioural remote transmitter driving the receive line
`timescale 1ns/100ps
`default_nettype none
module ucrx_tx_model (
  input  wire logic clk_i,  // system clock
  output logic      line_o  // serial line, idles high
);
  initial line_o = 1'b1;
  task automatic put(input logic v, input int bc);
    @(posedge clk_i);
    line_o <= v;
    repeat (bc - 1) @(posedge clk_i);
  endtask : put
  // lsb first, optional parity, one stop bit, then one idle bit
  task automatic send(input logic [8:0] d, input int n, input int bc, input logic [1:0] pm,
                      input logic pbad, input logic stop);
    logic p;
    p = pm[0] ^ pbad;
    for (int i = 0; i < n; i++)
      p = p ^ d[i];
    put(1'b0, bc);
    for (int i = 0; i < n; i++)
      put(d[i], bc);
    if (pm[1])
      put(p, bc);
    put(stop, bc);
    put(1'b1, bc);
  endtask : send
  // short low pulse, too brief to pass the start vote
  task automatic glitch(input int len);
    put(1'b0, len);
    put(1'b1, 16);
  endtask : glitch
endmodule : ucrx_tx_model
`default_nettype wire

//--- dv/test_ucrx_receiver.sv
// self-checking bench for the serial receive block
`timescale 1ns/100ps
`default_nettype none
module test_ucrx_receiver
  import ucrx_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, gie = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic        ack, irq, ovr, line;
  int          errors = 0;
  int          comparisons = 0;
  ucrx_receiver i_ucrx_receiver (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .global_irq_en_i(gie),
    .serial_receive_pin_i(line), .rx_pin_override_o(ovr), .rx_irq_o(irq)
  );
  ucrx_tx_model i_ucrx_tx_model (.clk_i(clk_i), .line_o(line));
  initial forever #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // request held until ack is sampled, then released for a cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : bus
  task automatic rd(input logic [4:0] a, input string what, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(what, q, exp);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic tx(input logic [8:0] d, input int n = 8, input logic [1:0] pm = 2'b00,
                    input logic pbad = 1'b0, input logic stop = 1'b1, input int bc = 16);
    i_ucrx_tx_model.send(d, n, bc, pm, pbad, stop);
  endtask : tx
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(OFS_CONTROL_B, "ctrl b", {24'h0, RST_CONTROL_B});
    rd(OFS_CONTROL_C, "ctrl c", {24'h0, RST_CONTROL_C});
    rd(OFS_STATUS_A, "status", 32'h0);
    rd(5'h14, "unmapped", 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_irq();
    wr(OFS_CONTROL_B, 8'h90);
    tx(9'h0a5);
    rd(OFS_STATUS_A, "rxc set", 32'h80);
    chk("irq gated", irq, 32'h0);
    gie <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("irq", irq, 32'h1);
    rd(OFS_DATA, "data", 32'ha5);
    repeat (3) @(posedge clk_i);
    chk("irq clear", irq, 32'h0);
    rd(OFS_STATUS_A, "rxc clear", 32'h0);
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_nine();
    wr(OFS_CONTROL_B, 8'h14);
    tx(9'h1c3, 9);
    tx(9'h055, 9);
    rd(OFS_CONTROL_B, "ninth set", 32'h16);
    rd(OFS_DATA, "nine 1", 32'hc3);
    rd(OFS_CONTROL_B, "ninth clear", 32'h14);
    rd(OFS_DATA, "nine 2", 32'h55);
    $display("test nine bit done");
  endtask : t_nine
  task automatic t_errors();
    wr(OFS_CONTROL_B, 8'h10);
    wr(OFS_CONTROL_C, 8'h26);
    tx(9'h003, 8, 2'b10);
    tx(9'h007, 8, 2'b10, 1'b1);
    rd(OFS_STATUS_A, "parity ok", 32'h80);
    rd(OFS_DATA, "par 1", 32'h03);
    wr(OFS_STATUS_A, 8'h00);
    rd(OFS_STATUS_A, "parity bad", 32'h84);
    wr(OFS_CONTROL_C, 8'h06);
    rd(OFS_STATUS_A, "parity off", 32'h80);
    wr(OFS_CONTROL_C, 8'h36);
    rd(OFS_DATA, "par 2", 32'h07);
    tx(9'h001, 8, 2'b11);
    tx(9'h05a, 8, 2'b11, 1'b0, 1'b0);
    rd(OFS_STATUS_A, "odd ok", 32'h80);
    rd(OFS_DATA, "odd", 32'h01);
    rd(OFS_STATUS_A, "frame err", 32'h90);
    rd(OFS_DATA, "framed", 32'h5a);
    wr(OFS_CONTROL_C, 8'h06);
    $display("test error flags done");
  endtask : t_errors
  task automatic t_overrun();
    tx(9'h011);
    tx(9'h022);
    tx(9'h033);
    tx(9'h044);
    rd(OFS_DATA, "ovr 1", 32'h11);
    rd(OFS_STATUS_A, "ovr none", 32'h80);
    rd(OFS_DATA, "ovr 2", 32'h22);
    rd(OFS_STATUS_A, "ovr set", 32'h88);
    rd(OFS_DATA, "ovr 4", 32'h44);
    tx(9'h055);
    rd(OFS_STATUS_A, "ovr clear", 32'h80);
    rd(OFS_DATA, "ovr 5", 32'h55);
    $display("test overrun done");
  endtask : t_overrun
  task automatic t_disable();
    wr(OFS_CONTROL_B, 8'h90);
    tx(9'h0aa);
    fork
      tx(9'h0bb);
      begin
        repeat (60) @(posedge clk_i);
        wr(OFS_CONTROL_B, 8'h00);
      end
    join
    chk("pin released", ovr, 32'h0);
    chk("irq flushed", irq, 32'h0);
    wr(OFS_CONTROL_B, 8'h10);
    repeat (2) @(posedge clk_i);
    chk("pin claimed", ovr, 32'h1);
    rd(OFS_STATUS_A, "flushed", 32'h0);
    $display("test disable done");
  endtask : t_disable
  task automatic t_double();
    wr(OFS_STATUS_A, 8'h02);
    wr(OFS_CONTROL_C, 8'h00);
    i_ucrx_tx_model.glitch(2);
    rd(OFS_STATUS_A, "noise", 32'h02);
    tx(9'h0ff, 5, 2'b00, 1'b0, 1'b1, 8);
    rd(OFS_STATUS_A, "double", 32'h82);
    rd(OFS_DATA, "five bit", 32'h1f);
    wr(OFS_BAUD, 8'h03);
    tx(9'h00e, 5, 2'b00, 1'b0, 1'b1, 32);
    rd(OFS_DATA, "slow", 32'h0e);
    $display("test double speed done");
  endtask : t_double
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_irq();
    t_nine();
    t_errors();
    t_overrun();
    t_disable();
    t_double();
    tally_and_finish();
  end
  // whole run is under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
endmodule : test_ucrx_receiver
`default_nettype wire
